// *** bench/port1_soft_strap_defaults_sva.sv ***
// Purpose: Port-level checks of the soft-strap loader.
// Assumes: One clock, asynchronous active-high reset.
// Notes: Attached by bind at the foot of this file.
module port1_soft_strap_defaults_sva
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic [3:0] avs_address,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic [2:0] port1_mode,
  input wire logic [2:0] phy_mode,
  input wire logic eeprom_present,
  input wire logic duplex_pol_pin,
  input wire logic port1_fdx_indication_pin,
  input wire logic port1_mii_speed_lsb,
  input wire logic port1_mii_duplex,
  input wire logic phy_rate_select_lsb,
  input wire logic phy_full_duplex_bit,
  input wire logic adv_10_full,
  input wire logic adv_10_half,
  input wire logic adv_asym_pause,
  input wire logic port1_backpressure_enable,
  input wire logic port1_tx_pause_enable,
  input wire logic port1_rx_pause_enable,
  input wire logic port1_fdx_status,
  input wire logic strap_reload_pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] up;
  // ==========
  // Age since release; first edges still show reset values
  always @(posedge sys_clk or posedge reset)
    if (reset)
      up <= 3'h0;
    else if (up != 3'h7)
      up <= up + 3'h1;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ==========
  // Derived defaults
  a_speed_pair: assert property (port1_mii_speed_lsb == phy_rate_select_lsb)
    else $error("speed defaults disagree");
  a_mode_field: assert property (phy_mode == {1'b0, phy_rate_select_lsb, phy_full_duplex_bit})
    else $error("phy mode field wrong");
  a_adv_duplex: assert property (adv_10_full == phy_full_duplex_bit)
    else $error("10FD advert wrong");
  a_pause_pair: assert property (port1_tx_pause_enable == port1_rx_pause_enable)
    else $error("pause enables disagree");
  a_asym_pause: assert property (adv_asym_pause == port1_tx_pause_enable)
    else $error("asym advert wrong");
  a_fdx_follow: assert property (
    up > 3'h1 && port1_mode != 3'h3 && $past(port1_mode) != 3'h3
    |-> port1_fdx_status == phy_full_duplex_bit)
    else $error("fdx status not duplex strap");
  // ==========
  // Bus and control
  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("no bus answer");
  a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  a_pulse_ctl: assert property (avs_write && !avs_waitrequest && avs_address == 4'h8 &&
    avs_writedata[1:0] != 2'h0 |=> strap_reload_pulse ##1 !strap_reload_pulse)
    else $error("reload pulse wrong");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0
    |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  c_reload: cover property (strap_reload_pulse);
  c_mac_fdx: cover property (port1_mode == 3'h3 && port1_fdx_status);
  c_override: cover property (avs_write && !avs_waitrequest && avs_address == 4'h4);
endmodule
bind port1_soft_strap_defaults port1_soft_strap_defaults_sva chk (.*);

// *** bench/port1_soft_strap_defaults_tb.sv ***
// Purpose: Self-checking bench for the soft-strap loader.
// Assumes: No fixed bus answer time; pins settle within six.
// Notes: Expectations come from a strap model held in the bench.
module port1_soft_strap_defaults_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, reset = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd, seed;
  logic avs_waitrequest, eeprom_present, duplex_pol_pin, port1_fdx_indication_pin;
  logic pol_level = 1'b0, fdx_level = 1'b0, fitted = 1'b0, v;
  logic [2:0] port1_mode = 3'h7, phy_mode;
  logic [2:0] md [4] = '{3'h7, 3'h1, 3'h2, 3'h3};
  logic [4:0] act, lat;
  logic port1_mii_speed_lsb, port1_mii_duplex, phy_rate_select_lsb, phy_full_duplex_bit;
  logic adv_10_full, adv_10_half, adv_asym_pause, port1_backpressure_enable;
  logic port1_tx_pause_enable, port1_rx_pause_enable, port1_fdx_status, strap_reload_pulse;
  logic [13:0] outs;
  int err_total = 0, samples_checked = 0, cyc = 0;
  always #50 sys_clk = ~sys_clk;
  port1_soft_strap_defaults dut (.*);
  strap_pins_model pins (.sys_clk(sys_clk), .pol_level(pol_level), .fdx_level(fdx_level),
    .memory_fitted(fitted), .duplex_pol_pin(duplex_pol_pin),
    .port1_fdx_indication_pin(port1_fdx_indication_pin), .eeprom_present(eeprom_present));
  assign outs = {port1_fdx_status, port1_rx_pause_enable, port1_tx_pause_enable,
    port1_backpressure_enable, adv_asym_pause, adv_10_half, adv_10_full, phy_mode,
    phy_full_duplex_bit, phy_rate_select_lsb, port1_mii_duplex, port1_mii_speed_lsb};
  // ==========
  // Model and helpers
  function logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Strap vector to default vector; duplex pin polarity only counts in MAC mode
  function logic [13:0] model(input logic [4:0] s);
    logic st;
    st = (port1_mode == 3'h3) ? (s[2] ? fdx_level : ~fdx_level) : s[1];
    return {st, s[4], s[4], s[3], s[4], 1'b1, s[1], 1'b0, s[0], s[1], s[1], s[0], s[2], s[0]};
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    if (got !== exp)
      err_total++;
  endtask
  // One Avalon access; request held until waitrequest is seen low
  // No cycle count is assumed; the hang guard ends a wait that never closes
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= ~w;
    avs_write <= w;
    do
      @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task do_reset();
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (8) @(posedge sys_clk);
    lat = {2'h3, (port1_mode inside {3'h1, 3'h2, 3'h3}) ? pol_level : 1'b0,
      port1_mode == 3'h7, 1'b1};
    act = lat;
    v = 1'b0;
  endtask
  task settle_chk();
    repeat (6) @(posedge sys_clk);
    chk({18'h0, outs}, {18'h0, model(act)});
    bus(1'b0, 4'hC, 32'h0);
    chk(rd, {18'h0, model(act)});
    bus(1'b0, 4'h0, 32'h0);
    chk(rd, {18'h0, 1'b1, 2'h0, lat, v, act});
    bus(1'b0, 4'h4, 32'h0);
    chk(rd, {26'h0, v, act});
  endtask
  task end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========
  // Hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      end_sim();
    end
  end
  // ==========
  // Main sequence
  initial
  begin
    seed = 32'hA5C2;
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr(seed);
      port1_mode <= md[i % 4];
      pol_level <= seed[0];
      fdx_level <= seed[1];
      do_reset();
      settle_chk();
      fdx_level <= ~fdx_level;
      settle_chk();
      $display("mode sweep %0d done", i);
    end
    port1_mode <= 3'h3;
    pol_level <= 1'b1;
    fitted <= 1'b1;
    do_reset();
    for (int i = 0; i < 3; i++)
    begin
      seed = lfsr(seed);
      bus(1'b1, 4'h4, seed);
      act = seed[4:0];
      v = 1'b1;
      settle_chk();
    end
    bus(1'b1, 4'h8, 32'h1);
    settle_chk();
    pol_level <= 1'b0;
    fitted <= 1'b0;
    repeat (2) @(posedge sys_clk);
    bus(1'b1, 4'h4, ~seed);
    settle_chk();
    bus(1'b1, 4'h8, 32'h2);
    act = lat;
    v = 1'b0;
    settle_chk();
    bus(1'b0, 4'h2, 32'h0);
    chk(rd, 32'h0);
    $display("override test done");
    end_sim();
  end
endmodule

// *** bench/strap_pins_model.sv ***
// Purpose: Strap pins and config memory presence beside the loader.
// Assumes: Levels come from the bench; pins move only on clock edges.
// Notes: Pins hold steady so any change seen is a real strap change.
module strap_pins_model
(
  input wire logic sys_clk,
  input wire logic pol_level,
  input wire logic fdx_level,
  input wire logic memory_fitted,
  output logic duplex_pol_pin = 1'b0,
  output logic port1_fdx_indication_pin = 1'b0,
  output logic eeprom_present = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // Pin drive
  always @(posedge sys_clk)
  begin
    duplex_pol_pin <= pol_level;
    port1_fdx_indication_pin <= fdx_level;
    eeprom_present <= memory_fitted;
  end
endmodule

// *** hw/pin_sync.v ***
// Purpose: Two-flop synchroniser bank for asynchronous pin levels.
// Assumes: Each bit is an independent level; no word coherence.
// Notes: First stage feeds only the second stage.
module pin_sync
#(
  parameter WIDTH = 2
)
(
  input wire sys_clk,
  input wire reset,
  input wire [WIDTH-1:0] pin_level,
  output reg [WIDTH-1:0] synced_level
);

  reg [WIDTH-1:0] first_stage;

  // ==========================================================
  // Two stages; metastability settles in the first one
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      first_stage <= {WIDTH{1'b0}};
      synced_level <= {WIDTH{1'b0}};
    end
    else
    begin
      first_stage <= pin_level;
      synced_level <= first_stage;
    end
  end

endmodule

// *** hw/port1_soft_strap_defaults.v ***
// Purpose: Port-1 soft-strap latch, override and register-default derivation.
// Assumes: reset is power-on or the external reset pin; pins are asynchronous.
// Notes: Defaults are presented continuously; control logic loads them on reset.
//
// The implementer's own choices: the placing of the registers and the Avalon-MM interface to the registers.
`include "strap_consts.vh"

// Notes on behaviour
// (RQ1) Speed strap gives the MII basic control speed LSB default, default one.
// (RQ2) Speed strap also sets PHY speed LSB and 10 Mb/s advertisement defaults; the code ties the 10 Mb/s half-duplex advertisement to one.
// (RQ3) Speed and duplex straps together set the three-bit PHY mode default.
// (RQ4) Duplex strap sets the internal Phy_full_duplex_bit bit default.
// (RQ5) Duplex strap also sets the 10 Mb/s full-duplex advertisement default.
// (RQ6) Duplex strap defaults to one in internal PHY mode, zero otherwise.
// (RQ7) Duplex-polarity strap, from its pin in MII modes, gives MII duplex default.
// (RQ8) In MII MAC mode polarity strap sets how the duplex pin is read.
// (RQ9) Backpressure strap gives the backpressure-enable default, default one.
// (RQ10) Full-duplex pause strap gives transmit and receive pause enables, default one.
// (RQ11) Full-duplex pause strap also sets asymmetric pause advertisement default.
// (RQ12) Digital reset or reload reverts straps to latched values without EEPROM.
// (RQ13) Pins relatch only on power-on or external reset, never on soft reset.
module port1_soft_strap_defaults
(
  input wire sys_clk,
  input wire reset,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  input wire [2:0] port1_mode,
  input wire eeprom_present,
  input wire duplex_pol_pin,
  input wire port1_fdx_indication_pin,
  output reg port1_mii_speed_lsb,
  output reg port1_mii_duplex,
  output reg phy_rate_select_lsb,
  output reg phy_full_duplex_bit,
  output reg [2:0] phy_mode,
  output reg adv_10_full,
  output reg adv_10_half,
  output reg adv_asym_pause,
  output reg port1_backpressure_enable,
  output reg port1_tx_pause_enable,
  output reg port1_rx_pause_enable,
  output reg port1_fdx_status,
  output reg strap_reload_pulse
);

  // ==========================================================
  // Decode helpers
  function is_mii_mode;
    input [2:0] mode;
    begin
      is_mii_mode = (mode == `MODE_MII_PHY) || (mode == `MODE_RMII_PHY) ||
        (mode == `MODE_MII_MAC);
    end
  endfunction

  function is_internal_phy;
    input [2:0] mode;
    begin
      is_internal_phy = (mode == `MODE_INTERNAL_PHY);
    end
  endfunction

  // ==========================================================
  // Pin synchronisers
  wire [1:0] pins_synced;
  wire pol_pin_s;
  wire fdx_pin_s;

  pin_sync #(.WIDTH(2)) u_pin_sync
  (
    .sys_clk(sys_clk),
    .reset(reset),
    .pin_level({port1_fdx_indication_pin, duplex_pol_pin}),
    .synced_level(pins_synced)
  );

  assign pol_pin_s = pins_synced[0];
  assign fdx_pin_s = pins_synced[1];

  // ==========================================================
  // Strap state
  reg [1:0] settle_count;
  reg latched_done;
  reg [`STRAP_W-1:0] latched_straps;
  reg [`STRAP_W-1:0] active_straps;
  reg override_valid;
  reg [`STRAP_W-1:0] next_latched;
  reg soft_reload;
  reg bus_ack_write;
  reg bus_ack_read;

  // Bus handshake terms
  always @*
  begin
    bus_ack_write = avs_write && !avs_waitrequest;
    bus_ack_read = avs_read && !avs_waitrequest;
  end

  // Digital reset or reload command, written through control register
  always @*
  begin
    soft_reload = bus_ack_write && (avs_address == `OFS_STRAP_CONTROL) &&
      (avs_writedata[`CTL_DIGITAL_RESET] || avs_writedata[`CTL_RELOAD]);
  end

  // Values captured once the synchronised pins have settled after release
  always @*
  begin
    next_latched = `STRAPS_RESET;
    // (RQ1) speed defaults high
    next_latched[`STRAP_SPEED] = `STRAP_ONE;
    // (RQ6) duplex depends on mode
    next_latched[`STRAP_DUPLEX] = is_internal_phy(port1_mode) ? `STRAP_ONE : `STRAP_ZERO;
    // (RQ7) polarity from pin in MII modes
    next_latched[`STRAP_DUPLEX_POL] = is_mii_mode(port1_mode) ? pol_pin_s : `STRAP_ZERO;
    // (RQ9) backpressure defaults high
    next_latched[`STRAP_BACKPRESSURE] = `STRAP_ONE;
    // (RQ10) pause defaults high
    next_latched[`STRAP_FD_PAUSE] = `STRAP_ONE;
  end

  // ==========================================================
  // Latch straps after power-on or external reset only.
  // Sampling waits for the synchroniser so no stale reset zero is caught.
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      settle_count <= 2'h0;
      latched_done <= 1'b0;
      latched_straps <= `STRAPS_RESET;
    end
    else if (!latched_done)
    begin
      settle_count <= settle_count + 2'h1;
      // (RQ13) relatch only here
      if (settle_count == `SETTLE_CYCLES)
      begin
        latched_done <= 1'b1;
        latched_straps <= next_latched;
      end
    end
  end

  // ==========================================================
  // Active straps: latched values, or an EEPROM override when present.
  // A soft reload with no EEPROM drops the override; the pins are not looked at.
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      active_straps <= `STRAPS_RESET;
      override_valid <= 1'b0;
      strap_reload_pulse <= 1'b0;
    end
    else
    begin
      strap_reload_pulse <= soft_reload;
      if (!latched_done)
      begin
        active_straps <= next_latched;
      end
      // (RQ12) revert without EEPROM
      else if (soft_reload && !eeprom_present)
      begin
        override_valid <= 1'b0;
        active_straps <= latched_straps;
      end
      else if (bus_ack_write && (avs_address == `OFS_STRAP_OVERRIDE) && eeprom_present)
      begin
        override_valid <= 1'b1;
        active_straps <= avs_writedata[`STRAP_W-1:0];
      end
    end
  end

  // ==========================================================
  // Derived register defaults, recomputed every cycle from active straps
  reg [`DEF_W-1:0] next_def;
  reg spd;
  reg dpx;
  reg pol;

  always @*
  begin
    spd = active_straps[`STRAP_SPEED];
    dpx = active_straps[`STRAP_DUPLEX];
    pol = active_straps[`STRAP_DUPLEX_POL];
    next_def = {`DEF_W{1'b0}};
    // (RQ1) MII speed LSB
    next_def[`DEF_MII_SPEED] = spd;
    // (RQ7) MII duplex from polarity strap
    next_def[`DEF_MII_DUPLEX] = pol;
    // (RQ2) PHY speed and 10M advertisement
    next_def[`DEF_PHY_SPEED] = spd;
    next_def[`DEF_ADV_10HD] = `STRAP_ONE;
    // (RQ4) Phy_full_duplex_bit bit
    next_def[`DEF_PHY_FULL_DUPLEX_BIT] = dpx;
    // (RQ3) mode from speed and duplex
    next_def[`DEF_PHY_MODE_HI:`DEF_PHY_MODE_LO] = {1'b0, spd, dpx};
    // (RQ5) 10M full-duplex advertisement
    next_def[`DEF_ADV_10FD] = dpx;
    // (RQ11) asymmetric pause advertisement
    next_def[`DEF_ADV_ASYM] = active_straps[`STRAP_FD_PAUSE];
    // (RQ9) backpressure enable
    next_def[`DEF_BACKPRESSURE] = active_straps[`STRAP_BACKPRESSURE];
    // (RQ10) transmit and receive pause
    next_def[`DEF_TX_PAUSE] = active_straps[`STRAP_FD_PAUSE];
    next_def[`DEF_RX_PAUSE] = active_straps[`STRAP_FD_PAUSE];
    // (RQ8) pin polarity in MII MAC mode
    if (port1_mode == `MODE_MII_MAC)
    begin
      next_def[`DEF_FDX_STATUS] = pol ? fdx_pin_s : !fdx_pin_s;
    end
    else
    begin
      next_def[`DEF_FDX_STATUS] = dpx;
    end
  end

  // Output flops; during reset they hold fixed values, not those derived from STRAPS_RESET
  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      port1_mii_speed_lsb <= `STRAP_ONE;
      port1_mii_duplex <= `STRAP_ZERO;
      phy_rate_select_lsb <= `STRAP_ONE;
      phy_full_duplex_bit <= `STRAP_ONE;
      phy_mode <= `MODE_MII_MAC;
      adv_10_full <= `STRAP_ONE;
      adv_10_half <= `STRAP_ONE;
      adv_asym_pause <= `STRAP_ONE;
      port1_backpressure_enable <= `STRAP_ONE;
      port1_tx_pause_enable <= `STRAP_ONE;
      port1_rx_pause_enable <= `STRAP_ONE;
      port1_fdx_status <= `STRAP_ZERO;
    end
    else
    begin
      port1_mii_speed_lsb <= next_def[`DEF_MII_SPEED];
      port1_mii_duplex <= next_def[`DEF_MII_DUPLEX];
      phy_rate_select_lsb <= next_def[`DEF_PHY_SPEED];
      phy_full_duplex_bit <= next_def[`DEF_PHY_FULL_DUPLEX_BIT];
      phy_mode <= next_def[`DEF_PHY_MODE_HI:`DEF_PHY_MODE_LO];
      adv_10_full <= next_def[`DEF_ADV_10FD];
      adv_10_half <= next_def[`DEF_ADV_10HD];
      adv_asym_pause <= next_def[`DEF_ADV_ASYM];
      port1_backpressure_enable <= next_def[`DEF_BACKPRESSURE];
      port1_tx_pause_enable <= next_def[`DEF_TX_PAUSE];
      port1_rx_pause_enable <= next_def[`DEF_RX_PAUSE];
      port1_fdx_status <= next_def[`DEF_FDX_STATUS];
    end
  end

  // ==========================================================
  // Avalon-MM slave: one wait cycle per access, then the answer.
  // A fixed wait keeps read data registered without a bypass path.
  reg [31:0] next_readdata;

  always @*
  begin
    case (avs_address)
      `OFS_STRAP_STATUS:
        next_readdata = {18'h0, latched_done, 2'h0, latched_straps,
          override_valid, active_straps};
      `OFS_STRAP_OVERRIDE:
        next_readdata = {26'h0, override_valid, active_straps};
      `OFS_STRAP_CONTROL:
        next_readdata = {29'h0, eeprom_present, 2'h0};
      `OFS_DEFAULTS:
        next_readdata = {18'h0, next_def};
      default:
        next_readdata = 32'h0;
    endcase
  end

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end
    else
    begin
      // Release for exactly one cycle, then raise again for the next access
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest)
      begin
        avs_readdata <= next_readdata;
      end
      else if (bus_ack_read)
      begin
        avs_readdata <= avs_readdata; // Held through the accepting edge
      end
    end
  end

endmodule

// *** hw/strap_consts.vh ***
// Purpose: Shared constants for the port-1 soft-strap default loader.
// Assumes: Included by bare name; definitions only.
// Notes: Byte offsets are word aligned on a 32-bit Avalon-MM bus.
`ifndef STRAP_CONSTS_VH
`define STRAP_CONSTS_VH

// ==========================================================
// Register byte offsets
`define OFS_STRAP_STATUS 4'h0
`define OFS_STRAP_OVERRIDE 4'h4
`define OFS_STRAP_CONTROL 4'h8
`define OFS_DEFAULTS 4'hC

// ==========================================================
// Soft strap vector: bit positions
`define STRAP_W 5
`define STRAP_SPEED 0
`define STRAP_DUPLEX 1
`define STRAP_DUPLEX_POL 2
`define STRAP_BACKPRESSURE 3
`define STRAP_FD_PAUSE 4

// ==========================================================
// Control register bits and the override register valid bit
`define CTL_DIGITAL_RESET 0
`define CTL_RELOAD 1
`define OVR_VALID 5

// ==========================================================
// Port-1 mode field encodings
`define MODE_W 3
`define MODE_INTERNAL_PHY 3'h7
`define MODE_MII_PHY 3'h1
`define MODE_RMII_PHY 3'h2
`define MODE_MII_MAC 3'h3

// ==========================================================
// Reset values and timing
`define STRAP_ONE 1'h1
`define STRAP_ZERO 1'h0
`define STRAPS_RESET 5'h1D
`define SETTLE_CYCLES 2'h3

// ==========================================================
// Derived default vector: bit positions
`define DEF_W 14
`define DEF_MII_SPEED 0
`define DEF_MII_DUPLEX 1
`define DEF_PHY_SPEED 2
`define DEF_PHY_FULL_DUPLEX_BIT 3
`define DEF_PHY_MODE_LO 4
`define DEF_PHY_MODE_HI 6
`define DEF_ADV_10FD 7
`define DEF_ADV_10HD 8
`define DEF_ADV_ASYM 9
`define DEF_BACKPRESSURE 10
`define DEF_TX_PAUSE 11
`define DEF_RX_PAUSE 12
`define DEF_FDX_STATUS 13

`endif
